// ==== src/tam_pkg.sv ====
/*
  Shared constants and types for the trim and adjust-mode register bank:
  register indices, field positions, reset values, field codes and the
  decoded control bundle handed to the analog side.
  Assumes: included before every tam_* design file.
*/
// Notes on behaviour
// (R1) Coarse reference at 0x1B bits 4:0: bit 4 sign, bits 3:0 magnitude.
// (R2) Fine reference at 0x1C bits 5:0, magnitude only, sign from coarse bit 4.
// (R3) Judge threshold 10-bit signed, 0x1D bits 1:0 high, 0x1E low; range +-450.
// (R4) Volatile mode register 0x00: override 6:5, monitor 4:1, store power 0.
// (R5) Override 00 normal, 01 force positive, 10 force negative, 11 reserved.
// (R6) Monitor selector 0000 normal through 1001 judge threshold; above reserved.
// (R7) Store power bit 0 intermittent, 1 always on; set during adjustment.
// (R8) Temperature monitor needs the store bit; other monitor modes power store.
// (R9) Volatile mode register 0x01: source 5:4, offset 3, sensitivity 2, order 1:0.
// (R10) Source 00 external sensor, 01 reference, 10 internal 80mV, 11 reserved.
// (R11) Offset drift disable bit: 0 circuit active, 1 circuit disabled.
// (R12) Sensitivity drift disable bit: 0 circuit active, 1 circuit disabled.
// (R13) Order 00 normal, 01 second-order only, 10 first-order only, 11 reserved.
// (R14) Volatile override wins over the stored judge control field.
// (R15) Reserved bits and codes read zero; reserved code leaves default behaviour.
package tam_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_ADJ_ONE    = 6'h00;
  localparam logic [5:0] IDX_ADJ_TWO    = 6'h01;
  localparam logic [5:0] IDX_REF_COARSE = 6'h1B;
  localparam logic [5:0] IDX_REF_FINE   = 6'h1C;
  localparam logic [5:0] IDX_THR_HIGH   = 6'h1D;
  localparam logic [5:0] IDX_THR_LOW    = 6'h1E;

  // ==========================================================================
  // Field positions
  localparam int COARSE_SIGN_POS = 4;
  localparam int OVERRIDE_LSB    = 5;
  localparam int MONITOR_LSB     = 1;
  localparam int STORE_POS       = 0;
  localparam int SOURCE_LSB      = 4;
  localparam int OFS_DRIFT_POS   = 3;
  localparam int SENS_DRIFT_POS  = 2;
  localparam int ORDER_LSB       = 0;

  // ==========================================================================
  // Writable masks and reset values
  localparam logic [7:0] MASK_ADJ_ONE    = 8'h7F;
  localparam logic [7:0] MASK_ADJ_TWO    = 8'h3F;
  localparam logic [7:0] MASK_REF_COARSE = 8'h1F;
  localparam logic [7:0] MASK_REF_FINE   = 8'h3F;
  localparam logic [7:0] MASK_THR_HIGH   = 8'h03;
  localparam logic [7:0] MASK_THR_LOW    = 8'hFF;
  localparam logic [7:0] RST_REG         = 8'h00;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] CODE2_NORMAL   = 2'h0;
  localparam logic [1:0] CODE2_RESERVED = 2'h3;
  localparam logic [1:0] OVR_FORCE_POS  = 2'h1;
  localparam logic [1:0] OVR_FORCE_NEG  = 2'h2;
  localparam logic [1:0] ORD_SECOND     = 2'h1;
  localparam logic [1:0] ORD_FIRST      = 2'h2;
  localparam logic [3:0] MON_NORMAL     = 4'h0;
  localparam logic [3:0] MON_TEMP       = 4'h4;
  localparam logic [3:0] MON_LAST       = 4'h9;
  localparam int         MON_COUNT      = 10;
  localparam logic signed [9:0] THR_MAX = 10'sh1C2;
  localparam logic signed [9:0] THR_MIN = -10'sh1C2;

  // Decoded control bundle
  typedef struct packed {
    logic              coarse_sign;
    logic [3:0]        coarse_mag;
    logic              fine_sign;
    logic [5:0]        fine_mag;
    logic signed [9:0] threshold;
    logic              threshold_ok;
    logic              force_positive;
    logic              force_negative;
    logic [3:0]        monitor_selector;
    logic              store_power_on;
    logic [1:0]        input_source_select;
    logic              offset_drift_on;
    logic              sensitivity_drift_on;
    logic              first_order_only;
    logic              second_order_only;
  } tam_ctrl_s;

endpackage

// ==== src/tam_wb_ack.sv ====
/*
  Classic Wishbone acknowledge generator: one-cycle ack for each request.
  Assumes: a classic single-cycle master that holds the request until ack.
*/
`timescale 1ns/10ps
`default_nettype none
module tam_wb_ack (
  // Clock, reset, enable
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // Request
  input  wire logic i_cyc,
  input  wire logic i_stb,
  // Answer
  output logic      o_ack,
  output logic      o_take
);

  // ==========================================================================
  // Handshake
  logic ack;
  logic next_ack;

  // Ack drops after one cycle so a held request is never taken twice
  assign o_take   = i_cyc & i_stb & ~ack & i_clk_en;
  assign next_ack = o_take;
  assign o_ack    = ack;

  // Ack register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else if (i_clk_en) begin
      ack <= next_ack;
    end
  end

endmodule
`default_nettype wire

// ==== src/tam_mode_decode.sv ====
/*
  Combinational decode of the stored register bytes into control fields.
  Assumes: inputs already hold only legal or defaulted codes.
*/
`timescale 1ns/10ps
`default_nettype none
module tam_mode_decode
  import tam_pkg::*;
(
  // Register bytes
  input  wire logic [7:0] i_adj_one,
  input  wire logic [7:0] i_adj_two,
  input  wire logic [7:0] i_coarse,
  input  wire logic [7:0] i_fine,
  input  wire logic [7:0] i_thr_high,
  input  wire logic [7:0] i_thr_low,
  // Stored judge control from the nonvolatile side
  input  wire logic [1:0] i_stored_judge_control,
  // Decoded bundle
  output tam_ctrl_s       o_ctrl
);

  // ==========================================================================
  // Field extraction
  wire logic [1:0]        override   = i_adj_one[OVERRIDE_LSB +: 2];
  wire logic [3:0]        monitor    = i_adj_one[MONITOR_LSB +: 4];
  wire logic [1:0]        order      = i_adj_two[ORDER_LSB +: 2];
  wire logic signed [9:0] thr        = {i_thr_high[1:0], i_thr_low};        // [R3]
  // Volatile override first, stored field only when volatile is normal
  wire logic [1:0]        judge_eff  = (override != CODE2_NORMAL) ?
                                       override : i_stored_judge_control;    // [R14]
  // Other adjust modes keep the store awake; temperature mode needs the bit
  wire logic              store_auto = (monitor != MON_NORMAL) && (monitor != MON_TEMP);

  // Outputs
  assign o_ctrl.coarse_sign          = i_coarse[COARSE_SIGN_POS];              // [R1]
  assign o_ctrl.coarse_mag           = i_coarse[3:0];                          // [R1]
  assign o_ctrl.fine_sign            = i_coarse[COARSE_SIGN_POS];              // [R2]
  assign o_ctrl.fine_mag             = i_fine[5:0];                            // [R2]
  assign o_ctrl.threshold            = thr;
  assign o_ctrl.threshold_ok         = (thr >= THR_MIN) && (thr <= THR_MAX);   // [R3]
  assign o_ctrl.force_positive       = (judge_eff == OVR_FORCE_POS);           // [R5]
  assign o_ctrl.force_negative       = (judge_eff == OVR_FORCE_NEG);           // [R5]
  assign o_ctrl.monitor_selector     = monitor;                                // [R6]
  assign o_ctrl.store_power_on       = i_adj_one[STORE_POS] | store_auto;      // [R7] [R8]
  assign o_ctrl.input_source_select  = i_adj_two[SOURCE_LSB +: 2];             // [R10]
  assign o_ctrl.offset_drift_on      = ~i_adj_two[OFS_DRIFT_POS];              // [R11]
  assign o_ctrl.sensitivity_drift_on = ~i_adj_two[SENS_DRIFT_POS];             // [R12]
  assign o_ctrl.first_order_only     = (order == ORD_FIRST);                   // [R13]
  assign o_ctrl.second_order_only    = (order == ORD_SECOND);                  // [R13]

endmodule
`default_nettype wire

// ==== src/tam_regs.sv ====
/*
  Trim and adjust-mode register bank top level: six 8-bit registers behind
  a classic Wishbone slave, with decoded and registered control outputs.
  Assumes: one clock, synchronous active-high reset, synchronous inputs,
  32-bit bus data with each register in the low byte of one aligned word.
*/
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module tam_regs
  import tam_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int DAT_W = 32
) (
  // Clock, reset, enable
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_clk_en,
  // Wishbone slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [ADR_W-1:0]   i_wb_adr,
  input  wire logic [DAT_W-1:0]   i_wb_dat,
  input  wire logic [DAT_W/8-1:0] i_wb_sel,
  output logic      [DAT_W-1:0]   o_wb_dat,
  output logic                    o_wb_ack,
  // Nonvolatile judge control field
  input  wire logic [1:0]         i_stored_judge_control,
  // Decoded controls
  output tam_ctrl_s               o_ctrl,
  output logic [MON_COUNT-1:0]    o_monitor_route
);

  // ==========================================================================
  // Elaboration checks
  // Index needs six address bits above the two byte bits
  generate
    if (ADR_W < 8) begin : g_bad_adr
      $error("tam_regs: ADR_W must be at least 8");
    end
    if (DAT_W < 8 || (DAT_W % 8) != 0) begin : g_bad_dat
      $error("tam_regs: DAT_W must be a multiple of 8, at least 8");
    end
  endgenerate

  // ==========================================================================
  // Functions
  // Reserved two-bit codes fall back to the default code
  function automatic logic [1:0] fix2(input logic [1:0] code);
    fix2 = (code == CODE2_RESERVED) ? CODE2_NORMAL : code;
  endfunction

  // Reserved monitor codes fall back to normal operation
  function automatic logic [3:0] fix_mon(input logic [3:0] code);
    fix_mon = (code > MON_LAST) ? MON_NORMAL : code;
  endfunction

  // Register index hit test, shared by write and read decode
  function automatic logic hit(input logic [5:0] idx, input logic [5:0] want);
    hit = (idx == want);
  endfunction

  // ==========================================================================
  // Bus handshake
  logic take;

  tam_wb_ack u_ack (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .i_cyc     (i_wb_cyc),
    .i_stb     (i_wb_stb),
    .o_ack     (o_wb_ack),
    .o_take    (take)
  );

  // ==========================================================================
  // Address decode
  // Upper address bits must be zero so aliases do not reach the bank
  wire logic [5:0] idx      = i_wb_adr[7:2];
  wire logic       upper_ok = (ADR_W == 8) ? 1'b1 : ~|(i_wb_adr >> 8);
  wire logic       wr_go    = take & i_wb_we & i_wb_sel[0] & upper_ok;
  wire logic       rd_go    = take & ~i_wb_we;

  wire logic sel_adj_one = upper_ok & hit(idx, IDX_ADJ_ONE);    // [R4]
  wire logic sel_adj_two = upper_ok & hit(idx, IDX_ADJ_TWO);    // [R9]
  wire logic sel_coarse  = upper_ok & hit(idx, IDX_REF_COARSE); // [R1]
  wire logic sel_fine    = upper_ok & hit(idx, IDX_REF_FINE);   // [R2]
  wire logic sel_thr_hi  = upper_ok & hit(idx, IDX_THR_HIGH);   // [R3]
  wire logic sel_thr_lo  = upper_ok & hit(idx, IDX_THR_LOW);    // [R3]

  // ==========================================================================
  // Write data cleanup
  wire logic [7:0] wbyte = i_wb_dat[7:0];

  // Mode register one: reserved bit 7 dropped, reserved codes defaulted
  wire logic [7:0] w_adj_one = {1'b0,
                                fix2(wbyte[OVERRIDE_LSB +: 2]),      // [R5] [R15]
                                fix_mon(wbyte[MONITOR_LSB +: 4]),    // [R6] [R15]
                                wbyte[STORE_POS]};                   // [R7]

  // Mode register two: bits 7:6 dropped, reserved codes defaulted
  wire logic [7:0] w_adj_two = {2'b00,
                                fix2(wbyte[SOURCE_LSB +: 2]),        // [R10] [R15]
                                wbyte[OFS_DRIFT_POS],                // [R11]
                                wbyte[SENS_DRIFT_POS],               // [R12]
                                fix2(wbyte[ORDER_LSB +: 2])};        // [R13] [R15]

  // Reference and threshold bytes keep only their field bits
  wire logic [7:0] w_coarse = wbyte & MASK_REF_COARSE;  // [R1] [R15]
  wire logic [7:0] w_fine   = wbyte & MASK_REF_FINE;    // [R2] [R15]
  wire logic [7:0] w_thr_hi = wbyte & MASK_THR_HIGH;    // [R3] [R15]
  wire logic [7:0] w_thr_lo = wbyte & MASK_THR_LOW;     // [R3]

  // ==========================================================================
  // Register storage
  // Both mode registers are volatile: reset returns them to normal mode
  logic [7:0] adj_one;
  logic [7:0] adj_two;
  logic [7:0] coarse;
  logic [7:0] fine;
  logic [7:0] thr_hi;
  logic [7:0] thr_lo;

  // Mode register one
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      adj_one <= RST_REG;                      // [R4]
    end else if (wr_go && sel_adj_one) begin
      adj_one <= w_adj_one;                    // [R4]
    end
  end

  // Mode register two
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      adj_two <= RST_REG;                      // [R9]
    end else if (wr_go && sel_adj_two) begin
      adj_two <= w_adj_two;                    // [R9]
    end
  end

  // Coarse reference
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      coarse <= RST_REG;                       // [R1]
    end else if (wr_go && sel_coarse) begin
      coarse <= w_coarse;
    end
  end

  // Fine reference
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      fine <= RST_REG;                         // [R2]
    end else if (wr_go && sel_fine) begin
      fine <= w_fine;
    end
  end

  // Threshold halves are written independently; software owns ordering
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      thr_hi <= RST_REG;                       // [R3]
      thr_lo <= RST_REG;
    end else if (wr_go) begin
      if (sel_thr_hi) begin
        thr_hi <= w_thr_hi;
      end
      if (sel_thr_lo) begin
        thr_lo <= w_thr_lo;
      end
    end
  end

  // ==========================================================================
  // Read path
  // Unmapped indices answer with zero so software sees a defined value
  wire logic [7:0] rd_byte =
    sel_adj_one ? adj_one :
    sel_adj_two ? adj_two :
    sel_coarse  ? coarse  :
    sel_fine    ? fine    :
    sel_thr_hi  ? thr_hi  :
    sel_thr_lo  ? thr_lo  : 8'h00;             // [R15]

  logic [DAT_W-1:0] rd_data;

  // Read data held until the next read is taken
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rd_data <= '0;
    end else if (rd_go) begin
      rd_data <= {{(DAT_W-8){1'b0}}, rd_byte};
    end
  end

  assign o_wb_dat = rd_data;

  // ==========================================================================
  // Control decode
  tam_ctrl_s next_ctrl;

  tam_mode_decode u_dec (
    .i_adj_one              (adj_one),
    .i_adj_two              (adj_two),
    .i_coarse               (coarse),
    .i_fine                 (fine),
    .i_thr_high             (thr_hi),
    .i_thr_low              (thr_lo),
    .i_stored_judge_control (fix2(i_stored_judge_control)),   // [R14] [R15]
    .o_ctrl                 (next_ctrl)
  );

  // ==========================================================================
  // Monitor routing one-hot
  // One line per internal quantity; line 0 means normal operation
  logic [MON_COUNT-1:0] next_route;

  genvar gi;
  generate
    for (gi = 0; gi < MON_COUNT; gi++) begin : g_route
      assign next_route[gi] = (adj_one[MONITOR_LSB +: 4] == 4'(gi));  // [R6]
    end
  endgenerate

  // ==========================================================================
  // Registered outputs
  // One cycle of latency after a write keeps the analog controls glitch free
  tam_ctrl_s            ctrl;
  logic [MON_COUNT-1:0] route;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ctrl  <= '{offset_drift_on: 1'b1, sensitivity_drift_on: 1'b1,
                 threshold_ok: 1'b1, default: '0};
      route <= MON_COUNT'(1);
    end else if (i_clk_en) begin
      ctrl  <= next_ctrl;
      route <= next_route;
    end
  end

  assign o_ctrl          = ctrl;
  assign o_monitor_route = route;

endmodule
`default_nettype wire

// ==== bench/tam_regs_chk.sv ====
/*
  Checker for the trim and adjust-mode register bank top level.
  Assumes: bound to tam_regs; one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module tam_regs_chk
  import tam_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int DAT_W = 32
) (
  // Clock, reset, enable
  input wire logic               i_clock,
  input wire logic               i_sys_rst,
  input wire logic               i_clk_en,
  // Wishbone slave
  input wire logic               i_wb_cyc,
  input wire logic               i_wb_stb,
  input wire logic               i_wb_we,
  input wire logic [ADR_W-1:0]   i_wb_adr,
  input wire logic [DAT_W-1:0]   i_wb_dat,
  input wire logic [DAT_W/8-1:0] i_wb_sel,
  input wire logic [DAT_W-1:0]   o_wb_dat,
  input wire logic               o_wb_ack,
  // Judge field and controls
  input wire logic [1:0]         i_stored_judge_control,
  input wire tam_ctrl_s          o_ctrl,
  input wire logic [MON_COUNT-1:0] o_monitor_route
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  // ==========================================================================
  // Read answers: bits above the two mode, coarse and threshold-high fields must come back zero
  wire rd_ack = o_wb_ack && !i_wb_we;
  AST_RD_ADJ_ONE: assert property (rd_ack && i_wb_adr == 8'h00 |-> o_wb_dat[DAT_W-1:7] == '0)
    else $error("adjust one read shows reserved bits");
  AST_RD_ADJ_TWO: assert property (rd_ack && i_wb_adr == 8'h04 |-> o_wb_dat[DAT_W-1:6] == '0)
    else $error("adjust two read shows reserved bits");
  AST_RD_COARSE: assert property (rd_ack && i_wb_adr == 8'h6C |-> o_wb_dat[DAT_W-1:5] == '0)
    else $error("coarse read shows bits above the field");
  AST_RD_THR_HI: assert property (rd_ack && i_wb_adr == 8'h74 |-> o_wb_dat[DAT_W-1:2] == '0)
    else $error("threshold high read shows bits above the field");

  // ==========================================================================
  // Bus answer: one ack pulse, one cycle after the request is taken
  AST_ACK_TAKE: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en |=> o_wb_ack ##1 !o_wb_ack)
    else $error("request not answered by a single ack pulse");

  // ==========================================================================
  // Decoded controls tied to each other and to reset
  AST_STORE_AUTO: assert property (o_ctrl.monitor_selector != 4'h0 && o_ctrl.monitor_selector != 4'h4 |-> o_ctrl.store_power_on)
    else $error("store not powered in automatic monitor mode");
  AST_JUDGE_EXCL: assert property (!(o_ctrl.force_positive && o_ctrl.force_negative))
    else $error("judge forced both ways");
  AST_ROUTE_HOT: assert property (o_monitor_route == (10'h001 << o_ctrl.monitor_selector))
    else $error("monitor route differs from selector");
  AST_ORDER_EXCL: assert property (!(o_ctrl.first_order_only && o_ctrl.second_order_only))
    else $error("both single order outputs on");
  AST_THR_RANGE: assert property (o_ctrl.threshold_ok == ($signed(o_ctrl.threshold) >= -450 && $signed(o_ctrl.threshold) <= 450))
    else $error("threshold range flag wrong");
  AST_FINE_SIGN: assert property (o_ctrl.fine_sign == o_ctrl.coarse_sign)
    else $error("fine sign does not follow coarse sign");
  AST_DRIFT_RST: assert property ($fell(i_sys_rst) |-> o_ctrl.offset_drift_on && o_ctrl.sensitivity_drift_on)
    else $error("drift circuits off after reset");
endmodule
bind tam_regs tam_regs_chk #(.ADR_W(ADR_W), .DAT_W(DAT_W)) u_chk (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
  .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_stored_judge_control(i_stored_judge_control), .o_ctrl(o_ctrl),
  .o_monitor_route(o_monitor_route));
`default_nettype wire

// ==== bench/tam_regs_bench.sv ====
/*
  Self-checking bench for the register bank: Wishbone tasks and checks.
  Assumes: one ack per request, controls valid one edge after a write.
*/
`timescale 1ns/10ps
`default_nettype none
module tam_regs_bench
  import tam_pkg::*;
;
  localparam logic [7:0] ADR_TAB [6] = '{8'h00, 8'h04, 8'h6C, 8'h70, 8'h74, 8'h78};
  localparam logic [7:0] ONE_TAB [6] = '{8'h01, 8'h0C, 8'h1F, 8'h3F, 8'h03, 8'hFF};
  localparam logic [9:0] THR_TAB [5] = '{10'h23E, 10'h23D, 10'h1C2, 10'h1C3, 10'h3FF};
  logic        i_clock = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [1:0]  sjc = 2'h0;
  logic [31:0] rdat;
  logic        ack;
  tam_ctrl_s   ctrl;
  logic [9:0]  route;
  int          err_count = 0;
  int          check_count = 0;

  // ==========================================================================
  // Clock and device
  always #5 i_clock = ~i_clock;
  tam_regs uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_stored_judge_control(sjc), .o_ctrl(ctrl),
    .o_monitor_route(route));

  // ==========================================================================
  // Verdict, comparison and bus tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds the request until ack is sampled; bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (ack !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Upper data bytes carry junk that must be ignored
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'hA5A5A5, d}, 4'hF, q);
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 4'hF, q);
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    give_verdict();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    logic [31:0] q;
    logic [1:0]  ej;
    logic [3:0]  ms;
    logic [1:0]  src;
    repeat (20) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rd(ADR_TAB[k], q);
      check("reset value", q, 32'h0);
    end
    check("route reset", {22'h0, route}, 32'h1);
    check("drift reset", {30'h0, ctrl.offset_drift_on, ctrl.sensitivity_drift_on}, 32'h3);
    // All ones: reserved bits and codes come back zero
    for (int k = 0; k < 6; k++) begin
      wr(ADR_TAB[k], 8'hFF);
      rd(ADR_TAB[k], q);
      check("all ones", q, {24'h0, ONE_TAB[k]});
    end
    xfer(1'b1, 8'h70, 32'h0, 4'hE, q);
    rd(8'h70, q);
    check("lane zero off", q, 32'h3F);
    wr(8'h08, 8'h55);
    rd(8'h08, q);
    check("unmapped", q, 32'h0);
    // Reference offsets: fine follows coarse sign
    wr(8'h6C, 8'h1A);
    wr(8'h70, 8'h25);
    check("coarse", {27'h0, ctrl.coarse_sign, ctrl.coarse_mag}, 32'h1A);
    check("fine", {25'h0, ctrl.fine_sign, ctrl.fine_mag}, 32'h65);
    wr(8'h6C, 8'h05);
    check("fine sign", {31'h0, ctrl.fine_sign}, 32'h0);
    // Enable low freezes the bank: the request waits and the controls hold
    @(posedge i_clock);
    clk_en <= 1'b0;
    sjc <= 2'h1;
    fork
      xfer(1'b1, 8'h6C, 32'h1F, 4'hF, q);
      begin
        repeat (4) @(posedge i_clock);
        check("frozen", {30'h0, ack, ctrl.force_positive}, 32'h0);
        clk_en <= 1'b1;
      end
    join
    rd(8'h6C, q);
    check("after enable", {q[7:0], 23'h0, ctrl.force_positive}, 32'h1F000001);
    // Threshold at and just past both range ends
    for (int k = 0; k < 5; k++) begin
      wr(8'h74, {6'h0, THR_TAB[k][9:8]});
      wr(8'h78, THR_TAB[k][7:0]);
      check("threshold", {22'h0, ctrl.threshold}, {22'h0, THR_TAB[k]});
      check("range flag", {31'h0, ctrl.threshold_ok}, {31'h0, ~k[0]});
    end
    // Judge: volatile override against stored field, every code
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clock);
      sjc <= k[3:2];
      wr(8'h00, {1'b0, k[1:0], 5'h00});
      ej = (k[1:0] == 2'h1 || k[1:0] == 2'h2) ? k[1:0] :
           (k[3:2] == 2'h1 || k[3:2] == 2'h2) ? k[3:2] : 2'h0;
      check("judge", {30'h0, ctrl.force_positive, ctrl.force_negative},
            {30'h0, ej == 2'h1, ej == 2'h2});
    end
    // Monitor selector, every code with store bit low and high
    for (int k = 0; k < 32; k++) begin
      wr(8'h00, {3'h0, k[4:0]});
      ms = (k[4:1] <= 4'h9) ? k[4:1] : 4'h0;
      check("monitor", {28'h0, ctrl.monitor_selector}, {28'h0, ms});
      check("route", {22'h0, route}, 32'h1 << ms);
      check("store power", {31'h0, ctrl.store_power_on},
            {31'h0, k[0] | (ms != 4'h0 && ms != 4'h4)});
    end
    // Second mode register, every value of the six field bits
    for (int k = 0; k < 64; k++) begin
      wr(8'h04, k[7:0]);
      src = (k[5:4] == 2'h3) ? 2'h0 : k[5:4];
      check("mode two", {26'h0, ctrl.input_source_select, ctrl.offset_drift_on,
            ctrl.sensitivity_drift_on, ctrl.first_order_only, ctrl.second_order_only},
            {26'h0, src, ~k[3], ~k[2], k[1:0] == 2'h2, k[1:0] == 2'h1});
      rd(8'h04, q);
      check("mode two read", q, {26'h0, src, k[3:2], (k[1:0] == 2'h3) ? 2'h0 : k[1:0]});
    end
    give_verdict();
  end
endmodule
`default_nettype wire
